// >>> pcm_pkg.sv
// pcm_pkg: constants, types and register map of the color matrix block
// assumes one 25 MHz clock and an AXI4-Lite master outside
// Function
// - outputs are gain row times RGB plus offset
// - two transforms: correction and luma conversion
// - transform_on bypasses or applies the correction
// - illuminant_preset picks the calibrated correction matrix
// - custom coefficients writable only under custom preset
// - luma conversion after correction and gamma
// - luma conversion follows pixel format, read-only enable
// - coefficient_value reads back the coefficient in use
// - vividness adjustment only while vividness_on is 1
// - controls usable only while image_pipe_on set
// - twelve coefficients: nine gains, three offsets
// - preset also loads red and blue balance ratios
package pcm_pkg;
  localparam int PIX_W = 8;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 12;
  localparam int COEF_NUM = 12;
  localparam int SAT_FRAC = 7;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ILLUM = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COEF_SEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_COEF_VAL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WB_RED = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_WB_BLUE = 8'h1c;

  localparam int CTRL_PIPE_BIT = 0;
  localparam int CTRL_XFORM_BIT = 1;
  localparam int CTRL_SAT_BIT = 2;
  localparam int CTRL_GAMMA_BIT = 3;
  localparam int CTRL_LUMAFMT_BIT = 4;
  localparam int CTRL_PICK_BIT = 5;
  localparam int STATUS_LUMA_BIT = 0;

  localparam logic [2:0] ILLUM_RESET = 3'h0;
  localparam logic [2:0] ILLUM_CUSTOM = 3'h7;
  localparam logic [3:0] COEF_SEL_RESET = 4'h0;
  localparam logic [3:0] COEF_SEL_LAST = 4'hb;
  localparam logic [7:0] SAT_RESET = 8'h80;
  localparam logic [15:0] COEF_ONE = 16'h1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // diagonal boost of each calibrated matrix, off-diagonals get minus half, custom entry last
  localparam logic [15:0] PRESET_SPREAD [8] = '{16'h0000, 16'h0300,
    16'h0280, 16'h0200, 16'h0180, 16'h0140, 16'h0100, 16'h0000};
  localparam logic [15:0] PRESET_WB_RED [8] = '{16'h1000, 16'h0c00,
    16'h0d00, 16'h0f00, 16'h1100, 16'h1300, 16'h1500, 16'h1000};
  localparam logic [15:0] PRESET_WB_BLUE [8] = '{16'h1000, 16'h2000,
    16'h1c00, 16'h1800, 16'h1400, 16'h1100, 16'h0f00, 16'h1000};
  localparam logic [15:0] WB_RESET = 16'h1000;

  typedef logic [2:0][PIX_W-1:0] pcm_pix_t;
  typedef logic [COEF_NUM-1:0][COEF_W-1:0] pcm_coef_t;

  // entries 0..8 gain row*3+col, 9..11 offset per channel
  localparam pcm_coef_t IDENTITY_COEF = {16'h0000, 16'h0000, 16'h0000,
    COEF_ONE, 16'h0000, 16'h0000, 16'h0000, COEF_ONE, 16'h0000,
    16'h0000, 16'h0000, COEF_ONE};
  localparam pcm_coef_t LUMA_COEF = {16'h0080, 16'h0080, 16'h0000,
    16'hfeb3, 16'hf94d, 16'h0800, 16'h0800, 16'hfab3, 16'hfd4d,
    16'h01d3, 16'h0964, 16'h04c9};

  typedef enum logic {PICK_CORRECTION, PICK_LUMA} pcm_picker_t;

  typedef struct packed {
    logic pipeOn;
    logic corrOn;
    logic satOn;
    logic gammaOn;
    logic lumaFmt;
    pcm_picker_t picker;
  } pcm_ctrl_t;
endpackage : pcm_pkg

// >>> pcm_matrix_unit.sv
// pcm_matrix_unit: 3x3 gain matrix plus offsets on one pixel
// assumes Q4.12 gains and integer offsets, combinational use
`timescale 1ns/10ps
module pcm_matrix_unit (
  input wire pcm_pkg::pcm_pix_t pixIn,
  input wire pcm_pkg::pcm_coef_t coef,
  output pcm_pkg::pcm_pix_t pixOut
);
  import pcm_pkg::*;

  localparam int ACC_W = 30;

  for (genvar r = 0; r < 3; r++) begin : gRow
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] prod [3];
    for (genvar c = 0; c < 3; c++) begin : gCol
      assign prod[c] = ACC_W'(signed'(coef[r*3+c]))
        * ACC_W'(signed'({1'b0, pixIn[c]}));
    end
    assign acc = prod[0] + prod[1] + prod[2]
      + (ACC_W'(signed'(coef[9+r])) <<< COEF_FRAC);
    // negative clamps to 0, above range to full scale
    assign pixOut[r] = acc[ACC_W-1] ? 8'h00 :
      (|acc[ACC_W-2:PIX_W+COEF_FRAC]) ? 8'hff :
      acc[PIX_W+COEF_FRAC-1:COEF_FRAC];
  end
endmodule : pcm_matrix_unit

// >>> pcm_color_matrix.sv
// pcm_color_matrix: color correction, vividness, gamma, luma stages
// assumes an AXI4-Lite master and stream partners on the same clock
`timescale 1ns/10ps
module pcm_color_matrix (
  input wire logic clk,
  input wire logic reset,
  input wire logic [pcm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pcm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic inValid,
  output logic inReady,
  input wire pcm_pkg::pcm_pix_t inPix,
  output logic outValid,
  input wire logic outReady,
  output pcm_pkg::pcm_pix_t outPix,
  output logic lumaActive,
  output logic [15:0] wbRedRatio,
  output logic [15:0] wbBlueRatio
);
  import pcm_pkg::*;

  pcm_ctrl_t ctrl_reg;
  logic [2:0] illum_reg;
  logic [3:0] coefSel_reg;
  pcm_coef_t custom_reg;
  logic [7:0] sat_reg;
  logic [15:0] wbRed_reg;
  logic [15:0] wbBlue_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic s1Valid_reg;
  logic s2Valid_reg;
  logic s3Valid_reg;
  pcm_pix_t s1Pix_reg;
  pcm_pix_t s2Pix_reg;
  pcm_pix_t s3Pix_reg;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  function automatic pcm_coef_t presetCoef(input logic [2:0] sel);
    pcm_coef_t m;
    logic [15:0] k;
    k = PRESET_SPREAD[sel];
    m = IDENTITY_COEF;
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 3; c++) begin
        m[r*3+c] = (r == c) ? 16'(COEF_ONE + k) : 16'(16'h0000 - (k >> 1));
      end
    end
    return m;
  endfunction : presetCoef

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a == OFS_CTRL || a == OFS_STATUS || a == OFS_ILLUM ||
      a == OFS_COEF_SEL || a == OFS_COEF_VAL || a == OFS_SAT ||
      a == OFS_WB_RED || a == OFS_WB_BLUE;
  endfunction : isMapped

  // active settings
  logic corrActive;
  logic satActive;
  logic gammaActive;
  pcm_coef_t corrCoef;
  pcm_coef_t pickedCoef;
  logic [15:0] selCoef;
  assign corrActive = ctrl_reg.pipeOn && ctrl_reg.corrOn;
  assign satActive = ctrl_reg.pipeOn && ctrl_reg.satOn;
  assign gammaActive = ctrl_reg.pipeOn && ctrl_reg.gammaOn;
  assign lumaActive = ctrl_reg.pipeOn && ctrl_reg.lumaFmt;
  assign corrCoef = (illum_reg == ILLUM_CUSTOM) ? custom_reg
    : presetCoef(illum_reg);
  assign pickedCoef = (ctrl_reg.picker == PICK_LUMA) ? LUMA_COEF
    : corrCoef;
  assign selCoef = pickedCoef[coefSel_reg];
  assign wbRedRatio = wbRed_reg;
  assign wbBlueRatio = wbBlue_reg;

  // register read view
  logic [31:0] ctrlView;
  logic [31:0] readMux;
  always_comb begin
    ctrlView = '0;
    ctrlView[CTRL_PIPE_BIT] = ctrl_reg.pipeOn;
    ctrlView[CTRL_XFORM_BIT] = (ctrl_reg.picker == PICK_LUMA)
      ? lumaActive : ctrl_reg.corrOn;
    ctrlView[CTRL_SAT_BIT] = ctrl_reg.satOn;
    ctrlView[CTRL_GAMMA_BIT] = ctrl_reg.gammaOn;
    ctrlView[CTRL_LUMAFMT_BIT] = ctrl_reg.lumaFmt;
    ctrlView[CTRL_PICK_BIT] = ctrl_reg.picker;
  end

  always_comb begin
    readMux = '0;
    unique case (araddr)
      OFS_CTRL: readMux = ctrlView;
      OFS_STATUS: readMux[STATUS_LUMA_BIT] = lumaActive;
      OFS_ILLUM: readMux[2:0] = illum_reg;
      OFS_COEF_SEL: readMux[3:0] = coefSel_reg;
      OFS_COEF_VAL: readMux = {{16{selCoef[15]}}, selCoef};
      OFS_SAT: readMux[7:0] = sat_reg;
      OFS_WB_RED: readMux[15:0] = wbRed_reg;
      OFS_WB_BLUE: readMux[15:0] = wbBlue_reg;
      default: readMux = '0;
    endcase
    if (!ctrl_reg.pipeOn && araddr != OFS_CTRL) begin
      readMux = '0;
    end
  end

  // write channel
  logic doWrite;
  logic colorWrite;
  logic [31:0] newCtrl;
  logic [31:0] newVal;
  assign awready = !awHeld_reg && !bValid_reg;
  assign wready = !wHeld_reg && !bValid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
  assign colorWrite = doWrite && ctrl_reg.pipeOn;
  assign newCtrl = mergeBytes(ctrlView, wData_reg, wStrb_reg);
  assign newVal = mergeBytes(32'h0000_0000, wData_reg, wStrb_reg);
  assign bvalid = bValid_reg;
  assign bresp = bResp_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else if (wvalid && wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= wdata;
      wStrb_reg <= wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // read channel
  assign arready = !rValid_reg;
  assign rvalid = rValid_reg;
  assign rdata = rData_reg;
  assign rresp = rResp_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      rValid_reg <= 1'b0;
      rData_reg <= '0;
      rResp_reg <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rValid_reg <= 1'b1;
      rData_reg <= readMux;
      rResp_reg <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rValid_reg <= 1'b0;
    end
  end

  // control register, pipe bit always writable
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= '0;
    end else if (doWrite && awAddr_reg == OFS_CTRL) begin
      ctrl_reg.pipeOn <= newCtrl[CTRL_PIPE_BIT];
      if (ctrl_reg.pipeOn) begin
        ctrl_reg.picker <= pcm_picker_t'(newCtrl[CTRL_PICK_BIT]);
        if (newCtrl[CTRL_PICK_BIT] == PICK_CORRECTION) begin
          ctrl_reg.corrOn <= newCtrl[CTRL_XFORM_BIT];
        end
        ctrl_reg.satOn <= newCtrl[CTRL_SAT_BIT];
        ctrl_reg.gammaOn <= newCtrl[CTRL_GAMMA_BIT];
        ctrl_reg.lumaFmt <= newCtrl[CTRL_LUMAFMT_BIT];
      end
    end
  end

  // preset choice and balance ratios
  always_ff @(posedge clk) begin
    if (reset) begin
      illum_reg <= ILLUM_RESET;
      wbRed_reg <= WB_RESET;
      wbBlue_reg <= WB_RESET;
    end else if (colorWrite && awAddr_reg == OFS_ILLUM) begin
      illum_reg <= newVal[2:0];
      wbRed_reg <= PRESET_WB_RED[newVal[2:0]];
      wbBlue_reg <= PRESET_WB_BLUE[newVal[2:0]];
    end else if (colorWrite && awAddr_reg == OFS_WB_RED) begin
      wbRed_reg <= newVal[15:0];
    end else if (colorWrite && awAddr_reg == OFS_WB_BLUE) begin
      wbBlue_reg <= newVal[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      coefSel_reg <= COEF_SEL_RESET;
    end else if (colorWrite && awAddr_reg == OFS_COEF_SEL
      && newVal[3:0] <= COEF_SEL_LAST) begin
      coefSel_reg <= newVal[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      custom_reg <= IDENTITY_COEF;
    end else if (colorWrite && awAddr_reg == OFS_COEF_VAL
      && illum_reg == ILLUM_CUSTOM
      && ctrl_reg.picker == PICK_CORRECTION) begin
      custom_reg[coefSel_reg] <= newVal[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sat_reg <= SAT_RESET;
    end else if (colorWrite && awAddr_reg == OFS_SAT) begin
      sat_reg <= newVal[7:0];
    end
  end

  // pixel pipeline: correction, vividness+gamma, luma conversion
  logic advance;
  pcm_pix_t corrPix;
  pcm_pix_t lumaPix;
  pcm_pix_t s2Next;
  assign advance = !s3Valid_reg || outReady;
  assign inReady = advance;
  assign outValid = s3Valid_reg;
  assign outPix = s3Pix_reg;

  pcm_matrix_unit corrUnit (
    .pixIn(inPix),
    .coef(corrCoef),
    .pixOut(corrPix)
  );

  pcm_matrix_unit lumaUnit (
    .pixIn(s2Pix_reg),
    .coef(LUMA_COEF),
    .pixOut(lumaPix)
  );

  logic [9:0] ySum;
  logic [7:0] yAvg;
  assign ySum = {2'b00, s1Pix_reg[0]} + {1'b0, s1Pix_reg[1], 1'b0}
    + {2'b00, s1Pix_reg[2]};
  assign yAvg = ySum[9:2];

  for (genvar ch = 0; ch < 3; ch++) begin : gChan
    logic signed [8:0] diff;
    logic signed [17:0] scaled;
    logic signed [17:0] satSum;
    logic [7:0] satPix;
    logic [15:0] gProd;
    logic [8:0] gSum;
    assign diff = signed'({1'b0, s1Pix_reg[ch]}) - signed'({1'b0, yAvg});
    assign scaled = diff * signed'({1'b0, sat_reg});
    assign satSum = signed'({10'h000, yAvg}) + (scaled >>> SAT_FRAC);
    assign satPix = !satActive ? s1Pix_reg[ch] : satSum[17] ? 8'h00 :
      (|satSum[16:8]) ? 8'hff : satSum[7:0];
    assign gProd = satPix * (8'hff - satPix);
    assign gSum = {1'b0, satPix} + {1'b0, gProd[15:8]};
    assign s2Next[ch] = !gammaActive ? satPix
      : gSum[8] ? 8'hff : gSum[7:0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1Valid_reg <= 1'b0;
      s2Valid_reg <= 1'b0;
      s3Valid_reg <= 1'b0;
    end else if (advance) begin
      s1Valid_reg <= inValid;
      s2Valid_reg <= s1Valid_reg;
      s3Valid_reg <= s2Valid_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1Pix_reg <= '0;
      s2Pix_reg <= '0;
      s3Pix_reg <= '0;
    end else if (advance) begin
      s1Pix_reg <= corrActive ? corrPix : inPix;
      s2Pix_reg <= s2Next;
      s3Pix_reg <= lumaActive ? lumaPix : s2Pix_reg;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic [2:0] wrIllum;
  assign wrIllum = wData_reg[2:0];

  AST_CORR_BYPASS: assert property (inValid && advance && !corrActive
    |=> s1Pix_reg == $past(inPix))
    else $error("correction not bypassed while off");
  AST_PRESET_IDENT: assert property (inValid && advance && corrActive
    && illum_reg == ILLUM_RESET |=> s1Pix_reg == $past(inPix))
    else $error("neutral preset altered the pixel");
  AST_LUMA_RO: assert property (doWrite && awAddr_reg == OFS_CTRL
    && wData_reg[CTRL_PICK_BIT] && wStrb_reg[0] |=> $stable(ctrl_reg.corrOn))
    else $error("luma enable write changed correction enable");
  AST_CUSTOM_GATE: assert property (doWrite && awAddr_reg == OFS_COEF_VAL
    && illum_reg != ILLUM_CUSTOM |=> $stable(custom_reg))
    else $error("custom coefficient written outside custom preset");
  AST_PRESET_WB: assert property (colorWrite && awAddr_reg == OFS_ILLUM
    && wStrb_reg[0] |=> wbRed_reg == PRESET_WB_RED[$past(wrIllum)]
    && wbBlue_reg == PRESET_WB_BLUE[$past(wrIllum)])
    else $error("preset did not load balance ratios");
  AST_PIPE_OFF_READ: assert property (arvalid && arready
    && !ctrl_reg.pipeOn && araddr != OFS_CTRL |=> rvalid && rdata == 32'h0)
    else $error("color register visible while pipe off");
  AST_LUMA_AFTER: assert property (s2Valid_reg && advance && !lumaActive
    |=> s3Pix_reg == $past(s2Pix_reg) ##0 s3Valid_reg)
    else $error("last stage altered pixel without luma");
  AST_SAT_OFF: assert property (s1Valid_reg && advance && !satActive
    && !gammaActive |=> s2Pix_reg == $past(s1Pix_reg))
    else $error("vividness applied while off");
  AST_COEF_READ: assert property (arvalid && arready && ctrl_reg.pipeOn
    && araddr == OFS_COEF_VAL |=> rdata[15:0] == $past(selCoef))
    else $error("coefficient readback mismatch");

  COV_CUSTOM_WRITE: cover property (colorWrite && awAddr_reg == OFS_COEF_VAL
    && illum_reg == ILLUM_CUSTOM);
  COV_LUMA_OUT: cover property (outValid && outReady && lumaActive);
  COV_STALL: cover property (outValid && !outReady ##1 outValid && outReady);
endmodule : pcm_color_matrix

// >>> pcm_stream_partner.sv
// pcm_stream_partner: upstream pixel source and downstream pixel sink
// assumes one clock shared with the color matrix block
`timescale 1ns/10ps
module pcm_stream_partner (
  input wire logic clk,
  input wire logic reset,
  input wire logic sendReq,
  input wire pcm_pkg::pcm_pix_t srcPix,
  input wire logic stallOn,
  output logic inValid,
  input wire logic inReady,
  output pcm_pkg::pcm_pix_t inPix,
  input wire logic outValid,
  output logic outReady,
  input wire pcm_pkg::pcm_pix_t outPix,
  output pcm_pkg::pcm_pix_t gotPix,
  output logic [15:0] gotCnt
);
  import pcm_pkg::*;
  logic phase_reg;
  // source holds a pixel until taken, then scrambles the bus
  always_ff @(posedge clk) begin
    if (reset) begin
      inValid <= 1'b0;
      inPix <= '0;
    end else if (sendReq) begin
      inValid <= 1'b1;
      inPix <= srcPix;
    end else if (inValid && inReady) begin
      inValid <= 1'b0;
      inPix <= ~inPix;
    end
  end
  // sink stalls every other cycle when asked
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= 1'b0;
      gotCnt <= '0;
      gotPix <= '0;
    end else begin
      phase_reg <= ~phase_reg;
      if (outValid && outReady) begin
        gotPix <= outPix;
        gotCnt <= gotCnt + 16'h0001;
      end
    end
  end
  assign outReady = !stallOn || phase_reg;
endmodule : pcm_stream_partner

// >>> tb.sv
// tb: register and pixel tests of the color matrix block
// assumes the stream partner model and a 25 MHz clock
`timescale 1ns/10ps
module tb;
  import pcm_pkg::*;
  logic clk, reset;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic inValid, inReady, outValid, outReady, lumaActive;
  pcm_pix_t inPix, outPix, srcPix, gotPix;
  logic [15:0] wbRedRatio, wbBlueRatio, gotCnt;
  logic sendReq, stallOn;
  logic [31:0] d;
  int fail_count = 0;
  int checks_done = 0;
  int k;

  pcm_color_matrix dut (.clk(clk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .inValid(inValid), .inReady(inReady), .inPix(inPix),
    .outValid(outValid), .outReady(outReady), .outPix(outPix),
    .lumaActive(lumaActive), .wbRedRatio(wbRedRatio),
    .wbBlueRatio(wbBlueRatio));
  pcm_stream_partner partner (.clk(clk), .reset(reset), .sendReq(sendReq),
    .srcPix(srcPix), .stallOn(stallOn), .inValid(inValid),
    .inReady(inReady), .inPix(inPix), .outValid(outValid),
    .outReady(outReady), .outPix(outPix), .gotPix(gotPix),
    .gotCnt(gotCnt));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_write(a, v, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, d, r);
    chk(d, exp);
  endtask : rd

  function automatic pcm_pix_t mk(input logic [7:0] rc, gc, bc);
    return {bc, gc, rc};
  endfunction : mk

  task automatic px(input pcm_pix_t p, input pcm_pix_t e);
    logic [15:0] c;
    int n;
    c = gotCnt;
    n = 0;
    @(posedge clk);
    srcPix <= p;
    sendReq <= 1'b1;
    @(posedge clk);
    sendReq <= 1'b0;
    while (gotCnt == c && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 40), 32'h1);
    chk(32'(gotPix), 32'(e));
  endtask : px

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {sendReq, stallOn, srcPix} = '0;
    k = int'(PRESET_SPREAD[1]);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    chk(32'(wbRedRatio), 32'h1000);
    chk(32'(lumaActive), 32'h0);
    wr(OFS_ILLUM, 32'h1);
    rd(OFS_SAT, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_ILLUM, 32'h0);
    rd(OFS_SAT, 32'h80);
    $display("test access done");
    wr(OFS_ILLUM, 32'h1);
    chk(32'(wbRedRatio), 32'(PRESET_WB_RED[1]));
    chk(32'(wbBlueRatio), 32'(PRESET_WB_BLUE[1]));
    px(mk(8'd64, 8'd0, 8'd0), mk(8'd64, 8'd0, 8'd0));
    wr(OFS_CTRL, 32'h3);
    px(mk(8'd64, 8'd0, 8'd0), mk(8'(64 * (4096 + k) / 4096), 8'd0, 8'd0));
    wr(OFS_COEF_SEL, 32'h1);
    rd(OFS_COEF_VAL, 32'(-k / 2));
    wr(OFS_COEF_VAL, 32'h5);
    rd(OFS_COEF_VAL, 32'(-k / 2));
    $display("test preset done");
    wr(OFS_ILLUM, 32'h7);
    chk(32'(wbRedRatio), 32'h1000);
    wr(OFS_COEF_SEL, 32'h0);
    wr(OFS_COEF_VAL, 32'h2000);
    wr(OFS_COEF_SEL, 32'h9);
    wr(OFS_COEF_VAL, 32'h5);
    wr(OFS_COEF_SEL, 32'hc);
    rd(OFS_COEF_SEL, 32'h9);
    rd(OFS_COEF_VAL, 32'h5);
    stallOn <= 1'b1;
    px(mk(8'd64, 8'd10, 8'd20), mk(8'd133, 8'd10, 8'd20));
    stallOn <= 1'b0;
    $display("test custom done");
    wr(OFS_CTRL, 32'h5);
    wr(OFS_SAT, 32'h0);
    px(mk(8'd40, 8'd80, 8'd120), mk(8'd80, 8'd80, 8'd80));
    wr(OFS_CTRL, 32'h1);
    px(mk(8'd40, 8'd80, 8'd120), mk(8'd40, 8'd80, 8'd120));
    wr(OFS_CTRL, 32'h9);
    px(mk(8'd128, 8'd0, 8'd255), mk(8'd191, 8'd0, 8'd255));
    $display("test vividness done");
    wr(OFS_CTRL, 32'h31);
    chk(32'(lumaActive), 32'h1);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_COEF_SEL, 32'h0);
    rd(OFS_COEF_VAL, {16'h0000, LUMA_COEF[0]});
    px(mk(8'd100, 8'd100, 8'd100), mk(8'd100, 8'd128, 8'd128));
    wr(OFS_CTRL, 32'h39);
    px(mk(8'd128, 8'd128, 8'd128), mk(8'd191, 8'd128, 8'd128));
    wr(OFS_CTRL, 32'h21);
    chk(32'(lumaActive), 32'h0);
    px(mk(8'd100, 8'd90, 8'd80), mk(8'd100, 8'd90, 8'd80));
    $display("test luma done");
    wr(OFS_WB_RED, 32'h1234);
    rd(OFS_WB_RED, 32'h1234);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_ILLUM, 32'h0);
    chk(32'(wbRedRatio), 32'(PRESET_WB_RED[0]));
    px(mk(8'd30, 8'd60, 8'd90), mk(8'd30, 8'd60, 8'd90));
    $display("test neutral done");
    axi_write(8'h20, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_read(8'h20, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    $display("test unmapped done");
    print_verdict();
  end
endmodule : tb
